//--- rtl/rtcm_top.v
`timescale 1ns/100ps
`include "rtcm_regs.vh"

module rtcm_top (
  input  wire CLOCK_I,
  input  wire RESETN_I,
  input  wire SCL_I,
  input  wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE_N_O,
  input  wire MAINS_TICK_INPUT_I,
  output wire IRQ_OUT_O,
  output wire IRQ_OUT_OE_N_O,
  output wire SQUARE_WAVE_PIN_O,
  output wire SQUARE_WAVE_PIN_OE_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam [3:0] S_IDLE  = 4'h0;  // Bus free or not addressed
  localparam [3:0] S_DEV   = 4'h1;  // Receiving slave address
  localparam [3:0] S_DACK  = 4'h2;  // Acking slave address
  localparam [3:0] S_WORD  = 4'h3;  // Receiving word address
  localparam [3:0] S_WACK  = 4'h4;  // Acking word address
  localparam [3:0] S_WDAT  = 4'h5;  // Receiving data byte
  localparam [3:0] S_WDACK = 4'h6;  // Acking data byte
  localparam [3:0] S_RDAT  = 4'h7;  // Sending data byte
  localparam [3:0] S_RACK  = 4'h8;  // Master ack slot

  reg  [2:0] scl_sy_r;              // Sync chain plus history
  reg  [2:0] sda_sy_r;              // Sync chain plus history
  reg  [2:0] tck_sy_r;              // Sync chain plus history
  reg  [3:0] state_r;               // Slave state
  reg  [3:0] cnt_r;                 // Bit counter
  reg  [7:0] shf_r;                 // Receive shift
  reg  [7:0] tx_r;                  // Transmit shift
  reg        rw_r;                  // Direction of transfer
  reg        drv_r;                 // Pulling SDA low
  reg  [3:0] ptr_r;                 // word_address pointer
  reg  [7:0] regs_r [0:15];         // User-visible copy
  reg  [7:0] int_r  [1:7];          // Internal time counters
  reg  [5:0] div_r;                 // Mains edge divider
  reg        tick_d_r;              // Second tick, delayed
  reg        flag_r;                // alarm_flag
  reg        pend_r;                // Alarm held off by pointer
  reg        irq_low_r;             // Irq pin pulled low
  reg        sq_o_r;                // Square data out
  reg        sq_oe_n_r;             // Square enable, low drives
  integer    i;

  wire       scl_hi   = scl_sy_r[1];
  wire       scl_rise = scl_sy_r[1] & ~scl_sy_r[2];
  wire       scl_fall = ~scl_sy_r[1] & scl_sy_r[2];
  wire       sda_in   = sda_sy_r[1];
  wire       start_c  = scl_hi & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
  wire       stop_c   = scl_hi & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
  wire       tck_rise = tck_sy_r[1] & ~tck_sy_r[2];
  wire       halted   = int_r[1][`RTCM_B_HALT];
  wire       freq60   = int_r[5][`RTCM_B_FREQ];
  wire [5:0] div_max  = freq60 ? `RTCM_DIV_60 : `RTCM_DIV_50;
  wire       sec_tick = tck_rise & ~halted & (div_r == div_max - 6'd1);
  wire       wr_clock = (state_r == S_WDACK) & scl_rise & ~ptr_r[3];
  wire       hold     = (state_r != S_IDLE) & ~ptr_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // BCD increment of a two-digit value, upper bits untouched
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Write mask, forces fixed-zero bits so they read back zero
  function [7:0] wmask;
    input [3:0] a;
    begin
      case (a)
        `RTCM_A_RSVD_LO:  wmask = 8'h00;
        `RTCM_A_MINUTES:  wmask = 8'h7f;
        `RTCM_A_HOURS:    wmask = 8'h3f;
        `RTCM_A_WEEKDAY:  wmask = 8'h07;
        `RTCM_A_DATE:     wmask = 8'hbf;
        `RTCM_A_CENT_MON: wmask = 8'hdf;
        `RTCM_A_OUT_LVL:  wmask = 8'h80;
        `RTCM_A_RSVD_HI:  wmask = 8'h00;
        `RTCM_A_ALARM_MONTH_CTRL: wmask = 8'hdf;
        `RTCM_A_FLAGS:    wmask = 8'h00;
        default:          wmask = 8'hff;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Calendar helpers
  wire [7:0] yr   = int_r[7];
  wire [1:0] cent = int_r[6][7:6];
  wire [4:0] mon  = int_r[6][4:0];
  // Divisible by four in BCD: even tens with 0/4/8, odd tens with 2/6
  wire       by4  = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                          : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                             yr[3:0] == 4'h8);
  // Only century count zero is a leap hundred
  wire       leap = by4 & ((yr != 8'h00) | (cent == 2'b00));
  reg  [5:0] dim;                   // Last date of month, BCD

  // Month length lookup
  always @* begin
    case (mon)
      5'h02:   dim = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   dim = 6'h30;
      default: dim = 6'h31;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage 0 feeds only stage 1
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_sy_r <= 3'b111;
      sda_sy_r <= 3'b111;
      tck_sy_r <= 3'b000;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], SCL_I};
      sda_sy_r <= {sda_sy_r[1:0], SDA_I};
      tck_sy_r <= {tck_sy_r[1:0], MAINS_TICK_INPUT_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave engine and register writes
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= S_IDLE;
      cnt_r   <= 4'h0;
      shf_r   <= 8'h00;
      tx_r    <= 8'h00;
      rw_r    <= 1'b0;
      drv_r   <= 1'b0;
      ptr_r   <= 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        regs_r[i] <= `RTCM_RST_ZERO;
      end
      regs_r[`RTCM_A_WEEKDAY]  <= `RTCM_RST_DAY;
      regs_r[`RTCM_A_DATE]     <= `RTCM_RST_DATE;
      regs_r[`RTCM_A_CENT_MON] <= `RTCM_RST_MONTH;
      regs_r[`RTCM_A_OUT_LVL]  <= `RTCM_RST_OUT;
    end else begin
      // User copy follows counters unless a clock address is in use
      if (!hold) begin
        for (i = 1; i < 8; i = i + 1) begin
          regs_r[i] <= int_r[i];
        end
      end
      if (start_c) begin
        // Start or repeated start, always back to address phase
        state_r <= S_DEV;
        cnt_r   <= 4'h0;
        drv_r   <= 1'b0;
      end else if (stop_c) begin
        state_r <= S_IDLE;
        drv_r   <= 1'b0;
      end else begin
        case (state_r)
          S_DEV, S_WORD, S_WDAT: begin
            if (scl_rise) begin
              shf_r <= {shf_r[6:0], sda_in};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `RTCM_BITS_BYTE) begin
              cnt_r <= 4'h0;
              if (state_r == S_DEV) begin
                if (shf_r[7:1] == `RTCM_SLAVE_ADDR) begin
                  rw_r    <= shf_r[0];
                  state_r <= S_DACK;
                  drv_r   <= 1'b1;
                end else begin
                  state_r <= S_IDLE;
                end
              end else begin
                state_r <= (state_r == S_WORD) ? S_WACK : S_WDACK;
                drv_r   <= 1'b1;
              end
            end
          end
          S_DACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                // Read starts at the held pointer
                tx_r    <= regs_r[ptr_r];
                drv_r   <= ~regs_r[ptr_r][7];
                state_r <= S_RDAT;
              end else begin
                drv_r   <= 1'b0;
                state_r <= S_WORD;
              end
            end
          end
          S_WACK: begin
            if (scl_rise) begin
              ptr_r <= shf_r[3:0];
            end else if (scl_fall) begin
              drv_r   <= 1'b0;
              state_r <= S_WDAT;
            end
          end
          S_WDACK: begin
            if (scl_rise) begin
              // Store on the ack clock, then advance
              regs_r[ptr_r] <= shf_r & wmask(ptr_r);
              ptr_r         <= ptr_r + 4'h1;
            end else if (scl_fall) begin
              drv_r   <= 1'b0;
              state_r <= S_WDAT;
            end
          end
          S_RDAT: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == `RTCM_BITS_BYTE) begin
                cnt_r   <= 4'h0;
                drv_r   <= 1'b0;                      // Release for ack
                state_r <= S_RACK;
              end else begin
                tx_r  <= {tx_r[6:0], 1'b0};
                drv_r <= ~tx_r[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              ptr_r <= ptr_r + 4'h1;
              rw_r  <= ~sda_in;                       // Master acked
            end else if (scl_fall) begin
              if (rw_r) begin
                tx_r    <= regs_r[ptr_r];
                drv_r   <= ~regs_r[ptr_r][7];
                state_r <= S_RDAT;
              end else begin
                state_r <= S_IDLE;                    // Nack, wait for stop
              end
            end
          end
          default: begin
            drv_r <= 1'b0;
          end
        endcase
      end
      // Flag register copy is built from the live flag
      regs_r[`RTCM_A_FLAGS] <= {1'b0, flag_r, 6'h00};
    end
  end

  // Flag byte loaded for sending in this cycle
  wire flag_load = ~start_c & ~stop_c & scl_fall & (ptr_r == `RTCM_A_FLAGS) &
                   (((state_r == S_DACK) & rw_r) | ((state_r == S_RACK) & rw_r));

  ////////////////////////////////////////////////////////////////////////////
  // Divider and internal time counters
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_r    <= 6'd0;
      tick_d_r <= 1'b0;
      int_r[1] <= `RTCM_RST_SEC;
      int_r[2] <= `RTCM_RST_ZERO;
      int_r[3] <= `RTCM_RST_ZERO;
      int_r[4] <= `RTCM_RST_DAY;
      int_r[5] <= `RTCM_RST_DATE;
      int_r[6] <= `RTCM_RST_MONTH;
      int_r[7] <= `RTCM_RST_ZERO;
    end else begin
      tick_d_r <= sec_tick;
      if (wr_clock) begin
        // Any clock-area write restarts the second; all but address 0 also reload time
        div_r <= 6'd0;
        if (ptr_r != `RTCM_A_RSVD_LO) begin
          int_r[ptr_r[2:0]] <= shf_r & wmask(ptr_r);
        end
      end else if (tck_rise && !halted) begin
        div_r <= sec_tick ? 6'd0 : div_r + 6'd1;
      end
      if (sec_tick && !wr_clock) begin
        // BCD cascade, control bits in the tops kept
        if (int_r[1][6:0] == 7'h59) begin
          int_r[1][6:0] <= 7'h00;
          if (int_r[2][6:0] == 7'h59) begin
            int_r[2][6:0] <= 7'h00;
            if (int_r[3][5:0] == 6'h23) begin
              int_r[3][5:0] <= 6'h00;
              int_r[4][2:0] <= (int_r[4][2:0] == 3'd7) ? 3'd1
                                                       : int_r[4][2:0] + 3'd1;
              if (int_r[5][5:0] == dim) begin
                int_r[5][5:0] <= 6'h01;
                if (mon == 5'h12) begin
                  int_r[6][4:0] <= 5'h01;
                  if (yr == 8'h99) begin
                    int_r[7]      <= 8'h00;
                    int_r[6][7:6] <= cent + 2'b01;
                  end else begin
                    int_r[7] <= bcd_inc(yr);
                  end
                end else begin
                  int_r[6] <= bcd_inc(int_r[6]);      // Century kept, month < 12
                end
              end else begin
                int_r[5] <= bcd_inc(int_r[5]);        // Select bit kept, tens < 3
              end
            end else begin
              int_r[3] <= bcd_inc(int_r[3]);          // Top bits zero by mask
            end
          end else begin
            int_r[2] <= bcd_inc(int_r[2]);            // Top bit zero by mask
          end
        end else begin
          int_r[1] <= bcd_inc(int_r[1]);              // Halt bit is zero here
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm match
  wire [4:0] rpt = {regs_r[`RTCM_A_ALARM_DATE][`RTCM_B_RPT5],
                    regs_r[`RTCM_A_ALARM_DATE][`RTCM_B_RPT],
                    regs_r[`RTCM_A_ALARM_HOUR][`RTCM_B_RPT],
                    regs_r[`RTCM_A_ALARM_MINUTES][`RTCM_B_RPT],
                    regs_r[`RTCM_A_ALARM_SECONDS][`RTCM_B_RPT]};
  wire m_sec = regs_r[`RTCM_A_ALARM_SECONDS][6:0]  == int_r[1][6:0];
  wire m_min = regs_r[`RTCM_A_ALARM_MINUTES][6:0]  == int_r[2][6:0];
  wire m_hr  = regs_r[`RTCM_A_ALARM_HOUR][5:0] == int_r[3][5:0];
  wire m_dt  = regs_r[`RTCM_A_ALARM_DATE][5:0] == int_r[5][5:0];
  wire m_mo  = regs_r[`RTCM_A_ALARM_MONTH_CTRL][4:0] == int_r[6][4:0];
  reg  match;                       // Selected fields agree

  // Unlisted mask codes fall back to every second
  always @* begin
    case (rpt)
      5'b11110: match = m_sec;
      5'b11100: match = m_sec & m_min;
      5'b11000: match = m_sec & m_min & m_hr;
      5'b10000: match = m_sec & m_min & m_hr & m_dt;
      5'b00000: match = m_sec & m_min & m_hr & m_dt & m_mo;
      default:  match = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm flag, pointer parked on flags defers the event
  wire hit      = tick_d_r & match;
  wire flag_set = (hit | pend_r) & (ptr_r != `RTCM_A_FLAGS);

  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      pend_r <= (hit | pend_r) & (ptr_r == `RTCM_A_FLAGS);
      // Set wins over the read clear
      flag_r <= flag_set | (flag_r & ~flag_load);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered
  wire afe  = regs_r[`RTCM_A_ALARM_MONTH_CTRL][`RTCM_B_AFE];
  wire square_wave_enable = regs_r[`RTCM_A_ALARM_MONTH_CTRL][`RTCM_B_SQUARE_WAVE_ENABLE];
  wire od   = regs_r[`RTCM_A_ALARM_HOUR][`RTCM_B_DRAIN];
  // High for the first half of each second
  wire sq   = square_wave_enable & ~halted & (div_r < {1'b0, div_max[5:1]});

  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_low_r <= 1'b0;
      sq_o_r    <= 1'b0;
      sq_oe_n_r <= 1'b0;
    end else begin
      irq_low_r <= afe ? flag_r
                       : ~regs_r[`RTCM_A_OUT_LVL][`RTCM_B_OUT];
      sq_o_r    <= od ? 1'b0 : sq;
      sq_oe_n_r <= od ? sq : 1'b0;
    end
  end

  assign SDA_O                  = 1'b0;
  assign SDA_OE_N_O             = ~drv_r;
  assign IRQ_OUT_O              = 1'b0;
  assign IRQ_OUT_OE_N_O         = ~irq_low_r;
  assign SQUARE_WAVE_PIN_O      = sq_o_r;
  assign SQUARE_WAVE_PIN_OE_N_O = sq_oe_n_r;

endmodule // rtcm_top

//--- rtl/rtcm_regs.vh
`ifndef RTCM_REGS_VH
`define RTCM_REGS_VH

// Register offsets
`define RTCM_A_RSVD_LO   4'h0
`define RTCM_A_SECONDS   4'h1
`define RTCM_A_MINUTES   4'h2
`define RTCM_A_HOURS     4'h3
`define RTCM_A_WEEKDAY   4'h4
`define RTCM_A_DATE      4'h5
`define RTCM_A_CENT_MON  4'h6
`define RTCM_A_YEAR      4'h7
`define RTCM_A_OUT_LVL   4'h8
`define RTCM_A_RSVD_HI   4'h9
`define RTCM_A_ALARM_MONTH_CTRL  4'ha
`define RTCM_A_ALARM_DATE   4'hb
`define RTCM_A_ALARM_HOUR   4'hc
`define RTCM_A_ALARM_MINUTES    4'hd
`define RTCM_A_ALARM_SECONDS    4'he
`define RTCM_A_FLAGS     4'hf

// Bit positions
`define RTCM_B_HALT      7
`define RTCM_B_FREQ      7
`define RTCM_B_OUT       7
`define RTCM_B_AFE       7
`define RTCM_B_SQUARE_WAVE_ENABLE      6
`define RTCM_B_DRAIN     6
`define RTCM_B_RPT       7
`define RTCM_B_RPT5      6
`define RTCM_B_FLAG      6

// Bus constants
`define RTCM_SLAVE_ADDR  7'h68
`define RTCM_BITS_BYTE   4'h8

// Reset values
`define RTCM_RST_SEC     8'h00
`define RTCM_RST_DAY     8'h01
`define RTCM_RST_DATE    8'h81
`define RTCM_RST_MONTH   8'h01
`define RTCM_RST_OUT     8'h80
`define RTCM_RST_ZERO    8'h00

// Divider counts per second
`define RTCM_DIV_50      6'd50
`define RTCM_DIV_60      6'd60

`endif

//--- verif/rtcm_chk.sv
`timescale 1ns/100ps
module rtcm_chk (
  input wire CLOCK_I,
  input wire RESETN_I,
  input wire SCL_I,
  input wire SDA_I,
  input wire SDA_OE_N_O,
  input wire MAINS_TICK_INPUT_I,
  input wire IRQ_OUT_OE_N_O,
  input wire SQUARE_WAVE_PIN_O,
  input wire SQUARE_WAVE_PIN_OE_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  ////////////////////////////////////////////////////////////////////////////////
  // A start leaves the device quiet for the next 8 cycles
  a_start_release: assert property (SCL_I && $past(SCL_I) && $fell(SDA_I) |=>
    SDA_OE_N_O [*8])
    else $error("data driven right after start");
  // Drive moves only once the clock fall has passed the sync chain
  a_sda_hold_time: assert property ($changed(SDA_OE_N_O) |-> !$past(SCL_I, 2))
    else $error("data drive changed too soon after clock fall");
  // Released square pin must not carry a high value
  a_sqw_od_low: assert property (SQUARE_WAVE_PIN_OE_N_O |-> !SQUARE_WAVE_PIN_O)
    else $error("square pin high while released");
  // Data drive moves only in clock low phase, else it would fake start or stop
  a_sda_low_phase: assert property ($changed(SDA_OE_N_O) |-> !SCL_I && !$past(SCL_I))
    else $error("data drive changed near clock high");
  a_sda_drive_hold: assert property ($fell(SDA_OE_N_O) |=> !SDA_OE_N_O [*8])
    else $error("data drive too short");
  // Out bit resets high, so both pins start released
  a_reset_release: assert property ($rose(RESETN_I) |-> SDA_OE_N_O && IRQ_OUT_OE_N_O)
    else $error("pins not released after reset");
  // Square wave is slow; a glitch means a broken divider compare
  a_sqw_steady: assert property ($changed(SQUARE_WAVE_PIN_OE_N_O) |=>
    $stable(SQUARE_WAVE_PIN_OE_N_O) [*8])
    else $error("square pin glitch");
  a_irq_steady: assert property ($changed(IRQ_OUT_OE_N_O) |=> $stable(IRQ_OUT_OE_N_O) [*4])
    else $error("irq pin glitch");

  c_ack: cover property ($fell(SDA_OE_N_O));
  c_irq: cover property ($fell(IRQ_OUT_OE_N_O));
  c_sqw: cover property ($rose(SQUARE_WAVE_PIN_OE_N_O));
endmodule // rtcm_chk

//--- verif/rtcm_master.sv
`timescale 1ns/100ps
module rtcm_i2c_master (
  input  wire clk_i,      // System clock
  output reg  scl_o,      // Bus clock, idle high, still between frames
  output reg  sda_oe_n_o, // Low while pulling data low
  input  wire sda_i       // Resolved data line
);
  localparam Q = 10;      // Quarter bit; keeps data edges far from clock edges

  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // One clock pulse; data set mid low phase, sampled mid high phase
  task bitx(input o, output v);
    begin
      wt(Q);
      sda_oe_n_o <= o;
      wt(Q);
      scl_o <= 1'b1;
      wt(Q);
      v = sda_i;
      wt(Q);
      scl_o <= 1'b0;
    end
  endtask
  // Start or repeated start: data falls while clock high
  task start;
    begin
      wt(Q);
      sda_oe_n_o <= 1'b1;
      wt(Q);
      scl_o <= 1'b1;
      wt(Q);
      sda_oe_n_o <= 1'b0;
      wt(Q);
      scl_o <= 1'b0;
    end
  endtask
  task stop;
    begin
      wt(Q);
      sda_oe_n_o <= 1'b0;
      wt(Q);
      scl_o <= 1'b1;
      wt(Q);
      sda_oe_n_o <= 1'b1;
      wt(Q);
    end
  endtask
  // Byte out MSB first, then release for the slave ack
  task put(input [7:0] d, output a);
    integer k;
    reg     v;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(d[k], v);
      bitx(1'b1, a);
    end
  endtask
  // Byte in, then ack, or nack on the last one
  task get(input nack, output [7:0] d);
    integer k;
    reg     v;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitx(1'b1, d[k]);
      bitx(nack, v);
    end
  endtask
endmodule // rtcm_i2c_master

//--- verif/rtcm_bench.sv
`timescale 1ns/100ps
module i2c_rtc_mains_clocked_bench;
  localparam LIMIT = 90000; // Cycle ceiling, about one and a half times the expected run
  reg         clk;          // 40 MHz system clock
  reg         rst_n;        // Active-low reset
  reg         tick;         // Mains time base, free running
  wire        scl;          // Bus clock from master
  wire        m_oe_n;       // Master pulls data low
  wire        sda;          // Resolved data line
  wire        d_sda;        // Device data value
  wire        d_oe_n;       // Device pulls data low
  wire        irq_o;        // Irq value
  wire        irq_oe_n;     // Irq pulled low
  wire        sqw_o;        // Square value
  wire        sqw_oe_n;     // Square released
  integer     failures;     // Mismatch count
  integer     compares;     // Comparison count
  integer     cyc;          // Timeout counter
  integer     i;            // Task loop index
  integer     j;            // Scenario loop index
  reg  [31:0] seed;         // Xorshift state
  reg  [31:0] r;            // Scratch random value
  reg         ak;           // Ack seen
  reg  [7:0]  wb [0:15];    // Bytes to write
  reg  [7:0]  eb [0:15];    // Bytes expected
  reg  [7:0]  gb [0:15];    // Bytes seen

  // Pull-up unless someone pulls low
  assign sda = (d_oe_n && m_oe_n) ? 1'b1 : 1'b0;

  rtcm_top DUT (
    .CLOCK_I               (clk),
    .RESETN_I              (rst_n),
    .SCL_I                 (scl),
    .SDA_I                 (sda),
    .SDA_O                 (d_sda),
    .SDA_OE_N_O            (d_oe_n),
    .MAINS_TICK_INPUT_I    (tick),
    .IRQ_OUT_O             (irq_o),
    .IRQ_OUT_OE_N_O        (irq_oe_n),
    .SQUARE_WAVE_PIN_O     (sqw_o),
    .SQUARE_WAVE_PIN_OE_N_O(sqw_oe_n)
  );
  rtcm_i2c_master m (.clk_i(clk), .scl_o(scl), .sda_oe_n_o(m_oe_n), .sda_i(sda));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Odd offset keeps tick edges off the system clock edges; the period is 8 clock cycles
  initial begin
    tick = 1'b0;
    #37.3;
    forever #100 tick = ~tick;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures = failures + 1;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] rnd(input [31:0] mx);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed % mx;
    end
  endfunction
  function [7:0] bcd(input [31:0] v);
    bcd = ((v / 10) << 4) | (v % 10);
  endfunction
  // Load n bytes, first byte leftmost, into expect or write list
  task ld(input ex, input [127:0] v, input integer n);
    for (i = 0; i < n; i = i + 1)
      if (ex) eb[i] = v[8*(n-1-i) +: 8];
      else wb[i] = v[8*(n-1-i) +: 8];
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chkp(input string nm, input e, input g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %b seen %b", nm, e, g);
      end
    end
  endtask
  task cmp(input integer n);
    for (i = 0; i < n; i = i + 1)
      chk("reg_byte", eb[i], gb[i]);
  endtask
  // Write n bytes at a; n of zero only sets the pointer
  task wr(input [7:0] a, input integer n);
    begin
      m.start;
      m.put(8'hd0, ak);
      chkp("ack_addr", 1'b0, ak);
      m.put(a, ak);
      chkp("ack_word", 1'b0, ak);
      for (i = 0; i < n; i = i + 1) begin
        m.put(wb[i], ak);
        chkp("ack_data", 1'b0, ak);
      end
      m.stop;
    end
  endtask
  // Read n bytes, from a when ad is set, stalling st cycles after the first
  task rd(input [7:0] a, input ad, input integer n, input integer st);
    begin
      m.start;
      if (ad) begin
        m.put(8'hd0, ak);
        m.put(a, ak);
        m.start;
      end
      m.put(8'hd1, ak);
      chkp("ack_read", 1'b0, ak);
      for (i = 0; i < n; i = i + 1) begin
        m.get(i == n - 1, gb[i]);
        if (i == 0) m.wt(st);
      end
      m.stop;
    end
  endtask
  task test_done;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    failures = 0;
    compares = 0;
    cyc = 0;
    seed = 32'd71635;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    m.wt(8);
    m.start;
    m.put(8'ha0, ak);
    m.stop;
    chkp("ack_other", 1'b1, ak);
    wr(8'h08, 0);
    rd(8'h00, 1'b0, 1, 0);
    ld(1, 8'h80, 1);
    cmp(1);
    chkp("sda_value", 1'b0, d_sda);
    chkp("irq_value", 1'b0, irq_o);
    chkp("sqw_reset", 1'b0, sqw_oe_n);
    rd(8'h02, 1'b1, 14, 0);
    ld(1, {8'h00, 8'h00, 8'h01, 8'h81, 8'h01, 8'h00, 8'h80, 56'h0}, 14);
    cmp(14);
    $display("test reset_map done");
    // Random calendar with halt set; time must stand still
    for (j = 0; j < 2; j = j + 1) begin
      wb[0] = 8'h80 | bcd(rnd(60));
      wb[1] = bcd(rnd(60));
      wb[2] = bcd(rnd(24));
      wb[3] = bcd(rnd(7) + 1);
      wb[4] = 8'h80 | bcd(rnd(28) + 1);
      r = rnd(4);
      wb[5] = {r[1:0], 6'h00} | bcd(rnd(12) + 1);
      wb[6] = bcd(rnd(100));
      wr(8'h01, 7);
      m.wt(1500);
      rd(8'h01, 1'b1, 7, 0);
      for (i = 0; i < 7; i = i + 1)
        eb[i] = wb[i];
      cmp(7);
    end
    $display("test random_time done");
    // About 1320 cycles from divider reset: 2 s at 60 Hz, 3 s at 50 Hz
    for (j = 1; j >= 0; j = j - 1) begin
      ld(0, {32'h00000001, j ? 8'h81 : 8'h01}, 5);
      wr(8'h01, 5);
      m.wt(1230);
      rd(8'h01, 1'b1, 1, 0);
      ld(1, j ? 8'h02 : 8'h03, 1);
      cmp(1);
    end
    $display("test mains_rate done");
    // Rollover of every field while the read holds the user copy
    // Year first, so the last write leaves the pointer on a clock address
    wb[0] = 8'h99;
    wr(8'h07, 1);
    ld(0, {8'h59, 8'h59, 8'h23, 8'h07, 8'hb1, 8'h12}, 6);
    wr(8'h01, 6);
    rd(8'h01, 1'b1, 7, 1500);
    ld(1, {8'h59, 8'h59, 8'h23, 8'h07, 8'hb1, 8'h12, 8'h99}, 7);
    cmp(7);
    rd(8'h02, 1'b1, 6, 0);
    ld(1, {8'h00, 8'h00, 8'h01, 8'h81, 8'h41, 8'h00}, 6);
    cmp(6);
    $display("test held_rollover done");
    // Alarm at second 02 each minute, open-drain square enabled
    ld(0, {8'hc1, 8'hc1, 8'hc0, 8'h80, 8'h02}, 5);
    wr(8'h0a, 5);
    ld(0, 8'h00, 1);
    wr(8'h01, 1);
    chkp("irq_early", 1'b1, irq_oe_n);
    m.wt(1500);
    chkp("irq_set", 1'b0, irq_oe_n);
    chkp("sqw_od", 1'b0, sqw_o);
    rd(8'h0f, 1'b1, 1, 0);
    ld(1, 8'h40, 1);
    cmp(1);
    m.wt(4);
    chkp("irq_clear", 1'b1, irq_oe_n);
    rd(8'h0f, 1'b1, 1, 0);
    ld(1, 8'h00, 1);
    cmp(1);
    $display("test alarm done");
    // Irq disabled: pin follows the out bit
    ld(0, 8'h01, 1);
    wr(8'h0a, 1);
    for (j = 0; j < 2; j = j + 1) begin
      wb[0] = j ? 8'h80 : 8'h00;
      wr(8'h08, 1);
      m.wt(4);
      chkp("irq_out", j[0], irq_oe_n);
    end
    $display("test out_pin done");
    test_done;
  end
endmodule // i2c_rtc_mains_clocked_bench

bind rtcm_top rtcm_chk u_chk (
  .CLOCK_I               (CLOCK_I),
  .RESETN_I              (RESETN_I),
  .SCL_I                 (SCL_I),
  .SDA_I                 (SDA_I),
  .SDA_OE_N_O            (SDA_OE_N_O),
  .MAINS_TICK_INPUT_I    (MAINS_TICK_INPUT_I),
  .IRQ_OUT_OE_N_O        (IRQ_OUT_OE_N_O),
  .SQUARE_WAVE_PIN_O     (SQUARE_WAVE_PIN_O),
  .SQUARE_WAVE_PIN_OE_N_O(SQUARE_WAVE_PIN_OE_N_O)
);
